// ==== hw/fwos_axil_port.v ====
// axi4-lite slave front end, one write and one read in flight
`include "fwos_defs.vh"
`default_nettype none
module fwos_axil_port (
	input wire sys_clk, // system clock
	input wire sys_rst, // synchronous reset, active high
	input wire [7:0] awaddr, // write address
	input wire awvalid, // write address valid
	output wire awready, // write address ready
	input wire [31:0] wdata, // write data
	input wire [3:0] wstrb, // write byte strobes
	input wire wvalid, // write data valid
	output wire wready, // write data ready
	output reg [1:0] bresp, // write response
	output reg bvalid, // write response valid
	input wire bready, // write response ready
	input wire [7:0] araddr, // read address
	input wire arvalid, // read address valid
	output wire arready, // read address ready
	output reg [31:0] rdata, // read data
	output reg [1:0] rresp, // read response
	output reg rvalid, // read data valid
	input wire rready, // read data ready
	output wire wr_en, // register write pulse
	output reg [7:0] wr_addr, // register write address
	output reg [31:0] wr_data, // register write data
	output reg [3:0] wr_strb, // register write strobes
	input wire wr_err, // write refused
	output wire rd_en, // register read pulse
	input wire [31:0] rd_data, // register read data
	input wire rd_err // read address unmapped
);
	reg aw_full_r;
	reg w_full_r;
	assign awready = !aw_full_r && !bvalid;
	assign wready = !w_full_r && !bvalid;
	assign wr_en = aw_full_r && w_full_r && !bvalid;
	assign arready = !rvalid;
	assign rd_en = arvalid && !rvalid;
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `FWOS_RESP_OK;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `FWOS_RESP_OK;
		end else begin
			if (awvalid && awready) begin
				aw_full_r <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_full_r <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_err ? `FWOS_RESP_ERR : `FWOS_RESP_OK;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (rd_en) begin
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_err ? `FWOS_RESP_ERR : `FWOS_RESP_OK;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule // fwos_axil_port
`default_nettype wire

// ==== hw/fwos_defs.vh ====
// constants of the flash write operation sequencer
`ifndef FWOS_DEFS_VH
`define FWOS_DEFS_VH
`define FWOS_A_CTL_LO 8'h00
`define FWOS_A_CTL_HI 8'h04
`define FWOS_A_SEC_LO 8'h08
`define FWOS_A_SEC_HI 8'h0C
`define FWOS_A_ADR_LO 8'h10
`define FWOS_A_ADR_HI 8'h14
`define FWOS_A_DAT0 8'h18
`define FWOS_A_DAT1 8'h1C
`define FWOS_A_DAT2 8'h20
`define FWOS_A_DAT3 8'h24
`define FWOS_A_ERR 8'h28
`define FWOS_A_TAU 8'h2C
`define FWOS_A_STAT 8'h30
`define FWOS_A_NV_WP 8'h34
`define FWOS_A_NV_AP0 8'h38
`define FWOS_A_NV_PDS 8'h3C
`define FWOS_A_NV_PEN 8'h40
`define FWOS_B_START 15
`define FWOS_B_SUSPEND_REQUEST 14
`define FWOS_B_SER 11
`define FWOS_SEL_MASK 16'h3900
`define FWOS_OP_WPG 16'h2000
`define FWOS_OP_DWORD_PROG_SELECT 16'h1000
`define FWOS_OP_SER 16'h0800
`define FWOS_OP_SPR 16'h0100
`define FWOS_PR_HI 16'h0008
`define FWOS_PR_WP 16'hDFB4
`define FWOS_PR_AP0 16'hDFB8
`define FWOS_PR_AP1 16'hDFBC
`define FWOS_NV_RST 16'hFFFF
`define FWOS_ZERO16 16'h0000
`define FWOS_B_ODD 2
`define FWOS_B_ACCP 0
`define FWOS_B_DBGP 1
`define FWOS_E_RESUME_ERROR_FLAG 0
`define FWOS_E_WPE 1
`define FWOS_E_PAE 2
`define FWOS_E_REJ 3
`define FWOS_STRB16 4'h3
`define FWOS_RESP_OK 2'h0
`define FWOS_RESP_ERR 2'h2
`define FWOS_CLK_NS 40
`define FWOS_PROG_NS 400
`define FWOS_DPROG_NS 600
`define FWOS_ERASE_NS 2000
`define FWOS_SPR_NS 400
`define FWOS_CYC(ns) (((ns) + `FWOS_CLK_NS - 1) / `FWOS_CLK_NS)
`endif

// ==== hw/fwos_op_timer.v ====
// down counter that stands in for the duration of one array operation
`default_nettype none
module fwos_op_timer (
	input wire sys_clk, // system clock
	input wire sys_rst, // synchronous reset, active high
	input wire load, // start a new count
	input wire [11:0] load_val, // cycles, at least one
	input wire run, // count only while high, hold otherwise
	output wire done // last counting cycle
);
	reg [11:0] cnt_r;
	assign done = run && (cnt_r == 12'h001);
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_r <= 12'h000;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (run && cnt_r != 12'h000) begin
			cnt_r <= cnt_r - 12'h001;
		end
	end
endmodule // fwos_op_timer
`default_nettype wire

// ==== hw/fwos_top.v ====
// flash write operation sequencer with its register file
`include "fwos_defs.vh"
`default_nettype none
module fwos_top (
	input wire sys_clk, // system clock, 25 MHz
	input wire sys_rst, // synchronous reset, active high
	input wire [7:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // write strobes
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output wire [1:0] s_axi_bresp, // write response
	output wire s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [7:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output wire [31:0] s_axi_rdata, // read data
	output wire [1:0] s_axi_rresp, // read response
	output wire s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire fetch_from_flash, // cpu currently fetches from flash
	output reg array_strobe_r, // one-cycle commit pulse to the array
	output reg [15:0] array_op_r, // select bits of committed op
	output reg [31:0] array_addr_r, // committed byte address
	output reg [63:0] array_data_r, // committed data, word 1 high
	output reg [31:0] array_sectors_r, // committed erase mask
	output wire access_protect_on, // access protection in force
	output wire debug_protect_on // debug protection in force
);
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_RUN = 2'h1;
	localparam [1:0] S_SUSPEND_REQUEST = 2'h2;
	localparam [1:0] S_NEST = 2'h3;
	localparam [31:0] PROG_CYC = `FWOS_CYC(`FWOS_PROG_NS);
	localparam [31:0] DPROG_CYC = `FWOS_CYC(`FWOS_DPROG_NS);
	localparam [31:0] ERASE_CYC = `FWOS_CYC(`FWOS_ERASE_NS);
	localparam [31:0] SPR_CYC = `FWOS_CYC(`FWOS_SPR_NS);

	wire wr_en;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	reg wr_err;
	reg rd_err;
	reg [31:0] rd_data;

	reg [1:0] state_r;
	reg [15:0] ctl_lo_r;
	reg [15:0] ctl_hi_r;
	reg [15:0] sec_lo_r;
	reg [15:0] sec_hi_r;
	reg [15:0] adr_lo_r;
	reg [15:0] adr_hi_r;
	reg [15:0] data_r [0:3];
	reg [3:0] err_r;
	reg temp_unprotect_bit_r;
	reg [15:0] nv_wp_r;
	reg [15:0] nv_ap0_r;
	reg [15:0] nv_pds_r;
	reg [15:0] nv_pen_r;
	reg [15:0] run_sel_r;
	reg [15:0] nest_sel_r;
	reg main_load;
	reg nest_load;
	reg [11:0] main_len;
	reg [11:0] nest_len;
	wire main_done;
	wire nest_done;

	wire [15:0] w16 = wr_data[15:0];
	wire [15:0] wsel = w16 & `FWOS_SEL_MASK;
	wire perm_dis = |(~nv_pds_r & nv_pen_r);
	wire prot = ~nv_ap0_r[`FWOS_B_ACCP] & ~temp_unprotect_bit_r & ~perm_dis;
	wire ctl_region = wr_addr <= `FWOS_A_DAT3;
	wire map_wr = ctl_region || wr_addr == `FWOS_A_ERR ||
		wr_addr == `FWOS_A_TAU;
	wire wr_ok = wr_en && !wr_err;
	wire wr_ctl = wr_ok && wr_addr == `FWOS_A_CTL_HI;
	wire wstart = w16[`FWOS_B_START];
	wire wsusp = w16[`FWOS_B_SUSPEND_REQUEST];
	wire sel_one = wsel == `FWOS_OP_WPG || wsel == `FWOS_OP_DWORD_PROG_SELECT ||
		wsel == `FWOS_OP_SER || wsel == `FWOS_OP_SPR;
	wire is_prog = wsel == `FWOS_OP_WPG || wsel == `FWOS_OP_DWORD_PROG_SELECT;
	wire prog_wp = !nv_wp_r[adr_lo_r[15:12]];
	wire erase_wp = |(sec_lo_r & ~nv_wp_r);
	wire launch_wp = (is_prog && prog_wp) ||
		(wsel == `FWOS_OP_SER && erase_wp);

	assign access_protect_on = prot;
	assign debug_protect_on = ~nv_ap0_r[`FWOS_B_DBGP] & ~perm_dis;

	fwos_axil_port u_port (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// erase or top-level op; frozen while suspended
	fwos_op_timer u_main_tmr (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(main_load),
		.load_val(main_len),
		.run(state_r == S_RUN),
		.done(main_done)
	);

	// program running inside an erase suspend
	fwos_op_timer u_nest_tmr (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(nest_load),
		.load_val(nest_len),
		.run(state_r == S_NEST),
		.done(nest_done)
	);

	// refusal of a write at the bus
	always @* begin
		wr_err = 1'b0;
		if (!map_wr)
			wr_err = 1'b1;
		if (wr_strb != `FWOS_STRB16)
			wr_err = 1'b1;
		if (ctl_region && prot)
			wr_err = 1'b1;
		if (wr_addr == `FWOS_A_TAU && w16[0] && !fetch_from_flash)
			wr_err = 1'b1;
	end

	always @* begin
		rd_err = 1'b0;
		rd_data = 32'h0000_0000;
		case (s_axi_araddr)
		`FWOS_A_CTL_LO: rd_data[15:0] = ctl_lo_r;
		`FWOS_A_CTL_HI: rd_data[15:0] = ctl_hi_r;
		`FWOS_A_SEC_LO: rd_data[15:0] = sec_lo_r;
		`FWOS_A_SEC_HI: rd_data[15:0] = sec_hi_r;
		`FWOS_A_ADR_LO: rd_data[15:0] = adr_lo_r;
		`FWOS_A_ADR_HI: rd_data[15:0] = adr_hi_r;
		`FWOS_A_DAT0: rd_data[15:0] = data_r[0];
		`FWOS_A_DAT1: rd_data[15:0] = data_r[1];
		`FWOS_A_DAT2: rd_data[15:0] = data_r[2];
		`FWOS_A_DAT3: rd_data[15:0] = data_r[3];
		`FWOS_A_ERR: rd_data[3:0] = err_r;
		`FWOS_A_TAU: rd_data[0] = temp_unprotect_bit_r;
		`FWOS_A_STAT: rd_data[5:0] = {perm_dis, debug_protect_on, prot,
			state_r == S_NEST, state_r == S_SUSPEND_REQUEST, state_r != S_IDLE};
		`FWOS_A_NV_WP: rd_data[15:0] = nv_wp_r;
		`FWOS_A_NV_AP0: rd_data[15:0] = nv_ap0_r;
		`FWOS_A_NV_PDS: rd_data[15:0] = nv_pds_r;
		`FWOS_A_NV_PEN: rd_data[15:0] = nv_pen_r;
		default: rd_err = 1'b1;
		endcase
	end

	// operation length and timer loads
	always @* begin
		main_load = 1'b0;
		nest_load = 1'b0;
		case (wsel)
		`FWOS_OP_WPG: main_len = PROG_CYC[11:0];
		`FWOS_OP_DWORD_PROG_SELECT: main_len = DPROG_CYC[11:0];
		`FWOS_OP_SER: main_len = ERASE_CYC[11:0];
		default: main_len = SPR_CYC[11:0];
		endcase
		nest_len = (wsel == `FWOS_OP_DWORD_PROG_SELECT) ? DPROG_CYC[11:0] :
			PROG_CYC[11:0];
		if (wr_ctl && wstart && !wsusp && sel_one && !launch_wp) begin
			if (state_r == S_IDLE)
				main_load = 1'b1;
			if (state_r == S_SUSPEND_REQUEST && run_sel_r == `FWOS_OP_SER &&
				is_prog)
				nest_load = 1'b1;
		end
	end

	// commit of a finished operation
	task finish_op;
		input [15:0] sel;
		begin
			ctl_hi_r <= `FWOS_ZERO16;
			if (sel == `FWOS_OP_SPR) begin
				if (adr_hi_r != `FWOS_PR_HI) begin
					err_r[`FWOS_E_PAE] <= 1'b1;
				end else begin
					case (adr_lo_r)
					`FWOS_PR_WP: nv_wp_r <= nv_wp_r & data_r[0];
					`FWOS_PR_AP0: nv_ap0_r <= nv_ap0_r & data_r[0];
					`FWOS_PR_AP1: begin
						// one-way bits cap the pairs at 16
						nv_pds_r <= nv_pds_r & data_r[0];
						nv_pen_r <= nv_pen_r & (data_r[1] | nv_pds_r);
					end
					default: err_r[`FWOS_E_PAE] <= 1'b1;
					endcase
				end
			end else begin
				array_strobe_r <= 1'b1;
				array_op_r <= sel;
				array_addr_r <= {adr_hi_r, adr_lo_r};
				if (sel == `FWOS_OP_DWORD_PROG_SELECT)
					array_addr_r[`FWOS_B_ODD] <= 1'b0;
				array_data_r <= {data_r[3], data_r[2], data_r[1],
					data_r[0]};
				array_sectors_r <= {sec_hi_r, sec_lo_r};
				if (sel == `FWOS_OP_SER) begin
					sec_lo_r <= `FWOS_ZERO16;
					sec_hi_r <= `FWOS_ZERO16;
				end
			end
		end
	endtask

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r <= S_IDLE;
			ctl_lo_r <= `FWOS_ZERO16;
			ctl_hi_r <= `FWOS_ZERO16;
			sec_lo_r <= `FWOS_ZERO16;
			sec_hi_r <= `FWOS_ZERO16;
			adr_lo_r <= `FWOS_ZERO16;
			adr_hi_r <= `FWOS_ZERO16;
			data_r[0] <= `FWOS_ZERO16;
			data_r[1] <= `FWOS_ZERO16;
			data_r[2] <= `FWOS_ZERO16;
			data_r[3] <= `FWOS_ZERO16;
			err_r <= 4'h0;
			temp_unprotect_bit_r <= 1'b0;
			nv_wp_r <= `FWOS_NV_RST;
			nv_ap0_r <= `FWOS_NV_RST;
			nv_pds_r <= `FWOS_NV_RST;
			nv_pen_r <= `FWOS_NV_RST;
			run_sel_r <= `FWOS_ZERO16;
			nest_sel_r <= `FWOS_ZERO16;
			array_strobe_r <= 1'b0;
			array_op_r <= `FWOS_ZERO16;
			array_addr_r <= 32'h0000_0000;
			array_data_r <= 64'h0000_0000_0000_0000;
			array_sectors_r <= 32'h0000_0000;
		end else begin
			array_strobe_r <= 1'b0;
			if (wr_en && wr_err)
				err_r[`FWOS_E_REJ] <= 1'b1;
			if (wr_ok) begin
				case (wr_addr)
				`FWOS_A_CTL_LO: ctl_lo_r <= w16;
				`FWOS_A_SEC_LO: sec_lo_r <= w16;
				`FWOS_A_SEC_HI: sec_hi_r <= w16;
				`FWOS_A_ADR_LO: adr_lo_r <= w16;
				`FWOS_A_ADR_HI: adr_hi_r <= w16;
				`FWOS_A_DAT0: data_r[0] <= w16;
				`FWOS_A_DAT1: data_r[1] <= w16;
				`FWOS_A_DAT2: data_r[2] <= w16;
				`FWOS_A_DAT3: data_r[3] <= w16;
				`FWOS_A_ERR: err_r <= err_r & w16[3:0];
				`FWOS_A_TAU: temp_unprotect_bit_r <= w16[0];
				default: ;
				endcase
			end
			case (state_r)
			S_IDLE: begin
				if (wr_ctl) begin
					ctl_hi_r <= w16;
					if (wstart && (wsusp || !sel_one)) begin
						ctl_hi_r[`FWOS_B_START] <= 1'b0;
					end else if (wstart && launch_wp) begin
						err_r[`FWOS_E_WPE] <= 1'b1;
						ctl_hi_r <= `FWOS_ZERO16;
					end else if (wstart) begin
						run_sel_r <= wsel;
						state_r <= S_RUN;
					end
				end
			end
			S_RUN: begin
				if (main_done) begin
					finish_op(run_sel_r);
					state_r <= S_IDLE;
				end else if (wr_ctl && wsusp &&
					run_sel_r != `FWOS_OP_SPR) begin
					ctl_hi_r <= run_sel_r | (16'h0001 << `FWOS_B_SUSPEND_REQUEST);
					state_r <= S_SUSPEND_REQUEST;
				end
			end
			S_SUSPEND_REQUEST: begin
				if (wr_ctl) begin
					ctl_hi_r <= w16;
					if (wstart && wsusp) begin
						ctl_hi_r[`FWOS_B_START] <= 1'b0;
					end else if (wstart && wsel == run_sel_r) begin
						state_r <= S_RUN;
					end else if (wstart && nest_load) begin
						nest_sel_r <= wsel;
						ctl_hi_r <= w16 & ~(`FWOS_OP_SER |
							(16'h0001 << `FWOS_B_SUSPEND_REQUEST));
						state_r <= S_NEST;
					end else if (wstart && is_prog && launch_wp &&
						run_sel_r == `FWOS_OP_SER) begin
						err_r[`FWOS_E_WPE] <= 1'b1;
						ctl_hi_r <= `FWOS_ZERO16;
					end else if (wstart) begin
						err_r[`FWOS_E_RESUME_ERROR_FLAG] <= 1'b1;
						ctl_hi_r <= `FWOS_ZERO16;
						state_r <= S_IDLE;
					end
				end
			end
			S_NEST: begin
				// suspend and other control writes are dropped while the program runs
				if (nest_done) begin
					finish_op(nest_sel_r);
					state_r <= S_SUSPEND_REQUEST;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // fwos_top
`default_nettype wire

// ==== test/flash_write_op_sequencer_tb.sv ====
// self-checking bench for the flash write operation sequencer
`default_nettype none
module flash_write_op_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, sys_rst, fetch_from_flash, array_strobe_r;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, access_protect_on, debug_protect_on;
	logic [31:0] s_axi_wdata, s_axi_rdata, array_addr_r, array_sectors_r;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [15:0] array_op_r, m [0:9];
	logic [63:0] array_data_r;
	logic [143:0] q [$], e;
	logic [31:0] seed;
	int fail_count, check_count;
	fwos_top u_fwos_top (.*);
	fwos_cpu_model u_cpu (.*);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		check_count++;
		if (g !== x) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic summarize;
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] x);
		u_cpu.write(a, d, 4'h3, r);
		chk(r, x);
		if (r === 2'h0 && a <= 8'h24)
			m[a[5:2]] = d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] x,
		input logic [1:0] xr);
		logic [15:0] d;
		logic [1:0] rr;
		u_cpu.read(a, d, rr);
		chk(d, x);
		chk(rr, xr);
	endtask
	// expected commit from the shadow registers
	task automatic push(input logic [15:0] o);
		logic [31:0] a;
		a = {m[5], m[4]};
		if (o == 16'h1000)
			a[2] = 1'b0;
		q.push_back({o, a, m[9], m[8], m[7], m[6], m[3], m[2]});
	endtask
	task automatic wait_q;
		int n;
		n = 0;
		while (q.size() != 0 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		chk(q.size(), 0);
	endtask
	task automatic setup(input logic [15:0] sel, lo);
		wr(8'h04, sel, 2'h0);
		wr(8'h10, lo, 2'h0);
		wr(8'h14, 16'h0002, 2'h0);
		for (int i = 6; i < 10; i++) begin
			seed = lfsr(seed);
			wr(8'(i * 4), seed[15:0], 2'h0);
		end
	endtask
	task automatic setp(input logic [15:0] lo, d0, d1);
		wr(8'h04, 16'h0100, 2'h0);
		wr(8'h10, lo, 2'h0);
		wr(8'h14, 16'h0008, 2'h0);
		wr(8'h18, d0, 2'h0);
		wr(8'h1C, d1, 2'h0);
		wr(8'h04, 16'h8100, 2'h0);
		repeat (14) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk)
		if (array_strobe_r === 1'b1) begin
			if (q.size() == 0)
				chk(1'b1, 1'b0);
			else begin
				e = q.pop_front();
				chk(array_op_r, e[143:128]);
				if (e[143:128] == 16'h0800)
					chk(array_sectors_r, e[31:0]);
				else begin
					chk(array_addr_r, e[127:96]);
					chk(e[143:128] == 16'h1000 ? array_data_r : array_data_r[31:0],
						e[143:128] == 16'h1000 ? e[95:32] : e[63:32]);
				end
			end
		end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		summarize;
	end
	initial begin
		sys_rst = 1'b1;
		fetch_from_flash = 1'b0;
		seed = 32'hB91D;
		for (int i = 0; i < 10; i++)
			m[i] = 16'h0000;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h34, 16'hFFFF, 2'h0);
		setup(16'h2000, 16'h5554);
		wr(8'h04, 16'hA000, 2'h0);
		push(16'h2000);
		wait_q;
		rd(8'h04, 16'h0000, 2'h0);
		setup(16'h1000, 16'h555C);
		wr(8'h04, 16'h9000, 2'h0);
		push(16'h1000);
		wait_q;
		wr(8'h08, 16'h0003, 2'h0);
		wr(8'h04, 16'h8800, 2'h0);
		push(16'h0800);
		wait_q;
		rd(8'h08, 16'h0000, 2'h0);
		rd(8'h0C, 16'h0000, 2'h0);
		// erase suspended, nested program, then resumed
		wr(8'h08, 16'h0002, 2'h0);
		wr(8'h04, 16'h8800, 2'h0);
		repeat (5) @(posedge sys_clk);
		wr(8'h04, 16'h4800, 2'h0);
		rd(8'h04, 16'h4800, 2'h0);
		rd(8'h30, 16'h0003, 2'h0);
		wr(8'h04, 16'h0000, 2'h0);
		setup(16'h2000, 16'h5554);
		wr(8'h04, 16'hA000, 2'h0);
		push(16'h2000);
		rd(8'h04, 16'hA000, 2'h0);
		wr(8'h04, 16'h6000, 2'h0);
		wait_q;
		wr(8'h04, 16'h8800, 2'h0);
		push(16'h0800);
		wait_q;
		// resume with another select aborts
		wr(8'h28, 16'h0000, 2'h0);
		wr(8'h04, 16'hA000, 2'h0);
		wr(8'h04, 16'h6000, 2'h0);
		wr(8'h04, 16'h9000, 2'h0);
		rd(8'h28, 16'h0001, 2'h0);
		rd(8'h04, 16'h0000, 2'h0);
		wr(8'h04, 16'hE000, 2'h0);
		rd(8'h04, 16'h6000, 2'h0);
		wr(8'h04, 16'h2000, 2'h0);
		wr(8'h04, 16'h0000, 2'h0);
		repeat (20) @(posedge sys_clk);
		u_cpu.write(8'h10, 16'h1234, 4'hF, r);
		chk(r, 2'h2);
		wr(8'h48, 16'h0000, 2'h2);
		rd(8'h44, 16'h0000, 2'h2);
		rd(8'h28, 16'h0009, 2'h0);
		wr(8'h28, 16'h0000, 2'h0);
		setp(16'hDFB4, 16'hFFF0, 16'hFFFF);
		rd(8'h34, 16'hFFF0, 2'h0);
		wr(8'h10, 16'h1554, 2'h0);
		wr(8'h04, 16'hA000, 2'h0);
		repeat (14) @(posedge sys_clk);
		rd(8'h28, 16'h0002, 2'h0);
		wr(8'h28, 16'h0000, 2'h0);
		setp(16'hDFB0, 16'hFFFF, 16'hFFFF);
		rd(8'h28, 16'h0004, 2'h0);
		setp(16'hDFB8, 16'hFFFC, 16'hFFFF);
		chk({access_protect_on, debug_protect_on}, 2'h3);
		wr(8'h04, 16'h0100, 2'h2);
		wr(8'h2C, 16'h0001, 2'h2);
		fetch_from_flash <= 1'b1;
		wr(8'h2C, 16'h0001, 2'h0);
		fetch_from_flash <= 1'b0;
		chk(access_protect_on, 1'b0);
		setp(16'hDFBC, 16'hFFFE, 16'hFFFF);
		rd(8'h3C, 16'hFFFE, 2'h0);
		chk(debug_protect_on, 1'b0);
		setp(16'hDFBC, 16'hFFFF, 16'hFFFE);
		rd(8'h40, 16'hFFFE, 2'h0);
		chk(debug_protect_on, 1'b1);
		wr(8'h2C, 16'h0000, 2'h0);
		chk(access_protect_on, 1'b1);
		summarize;
	end
endmodule // flash_write_op_sequencer_tb
`default_nettype wire

// ==== test/fwos_checker.sv ====
// port assertions for the flash write sequencer
`default_nettype none
module fwos_checker (
	input wire logic sys_clk, // clock
	input wire logic sys_rst, // reset
	input wire logic [7:0] s_axi_awaddr, // wr addr
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic [3:0] s_axi_wstrb, // strobes
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic array_strobe_r, // commit
	input wire logic [15:0] array_op_r, // commit op
	input wire logic [31:0] array_addr_r, // commit addr
	input wire logic access_protect_on // protected
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic wr_hs;
	assign wr_hs = s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready;
	chk_wr_answer: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
		else $error("write answer missing");
	chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	chk_wide_refused: assert property (wr_hs && s_axi_wstrb != 4'h3
		|-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("wide write accepted");
	chk_prot_refused: assert property (wr_hs && access_protect_on
		&& s_axi_awaddr <= 8'h24 |->
		##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("protected write accepted");
	chk_commit_pulse: assert property (array_strobe_r |=> !array_strobe_r)
		else $error("commit pulse too long");
	chk_commit_op: assert property (array_strobe_r |->
		array_op_r == 16'h2000 || array_op_r == 16'h1000 ||
		array_op_r == 16'h0800) else $error("bad commit op");
	chk_dword_even: assert property (array_strobe_r
		&& array_op_r == 16'h1000 |-> !array_addr_r[2]) else $error("odd dword");
	cover property (array_strobe_r && array_op_r == 16'h0800);
	cover property ($rose(access_protect_on));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // fwos_checker
bind fwos_top fwos_checker u_chk (.*);
`default_nettype wire

// ==== test/fwos_cpu_model.sv ====
// register bus master standing in for the cpu core
`default_nettype none
module fwos_cpu_model (
	input wire logic sys_clk, // clock
	output logic [7:0] s_axi_awaddr, // wr addr
	output logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	output logic [31:0] s_axi_wdata, // wr data
	output logic [3:0] s_axi_wstrb, // strobes
	output logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	output logic s_axi_bready, // b ready
	output logic [7:0] s_axi_araddr, // rd addr
	output logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	output logic s_axi_rready // r ready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1;
	end
	// one direct 16-bit register store, payload inverted once released
	task automatic write(input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic pa, pw;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(posedge sys_clk);
			if (pa && s_axi_awready) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (pw && s_axi_wready) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~{16'h0000, d};
			end
		end
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask
	task automatic read(input logic [7:0] a, output logic [15:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[15:0];
		r = s_axi_rresp;
	endtask
endmodule // fwos_cpu_model
`default_nettype wire
